// file: logic/pcgd_pkg.sv
package pcgd_pkg;

    // Port and bus widths
    localparam int PORT_W      = 4;
    localparam int GANG_W      = 7;
    localparam int REG_W       = 8;
    localparam int WB_DAT_W    = 32;
    localparam int WB_ADR_W    = 8;
    localparam int WB_SEL_W    = 4;
    localparam int SYNC_STAGES = 2;

    // Register byte offsets on the bus
    localparam logic [WB_ADR_W-1:0] OFS_DATA_LATCH = 8'h00;
    localparam logic [WB_ADR_W-1:0] OFS_DIRECTION  = 8'h04;
    localparam logic [WB_ADR_W-1:0] OFS_PULL_UP    = 8'h08;
    localparam logic [WB_ADR_W-1:0] OFS_SLEW_LIMIT = 8'h0c;
    localparam logic [WB_ADR_W-1:0] OFS_DRIVE_STR  = 8'h10;
    localparam logic [WB_ADR_W-1:0] OFS_GANG_CTRL  = 8'h14;

    // Field positions inside gang_drive_control
    localparam int GANG_EN_BIT  = 0;
    localparam int GANG_SEL_LSB = 1;
    localparam int GANG_SEL_MSB = 7;

    // Byte lane carrying the eight register bits
    localparam int REG_LANE = 0;

    // Reset values
    localparam logic [PORT_W-1:0] RST_DATA_LATCH = 4'h0;
    localparam logic [PORT_W-1:0] RST_DIRECTION  = 4'h0;
    localparam logic [PORT_W-1:0] RST_PULL_UP    = 4'h0;
    localparam logic [PORT_W-1:0] RST_SLEW_LIMIT = 4'h0;
    localparam logic [PORT_W-1:0] RST_DRIVE_STR  = 4'h0;
    localparam logic              RST_GANG_EN    = 1'h0;
    localparam logic [GANG_W:1]   RST_GANG_SEL   = 7'h00;

endpackage : pcgd_pkg

// file: logic/pcgd_sync.sv
`timescale 1ns/100ps
module pcgd_sync #(
    parameter int WIDTH = 4
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    import pcgd_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } pcgd_sync_s;

    pcgd_sync_s st_ff;
    pcgd_sync_s nxt_st;

    // First stage feeds only the second
    always_comb begin
        nxt_st        = st_ff;
        nxt_st.stage1 = async_i;
        nxt_st.stage2 = st_ff.stage1;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign sync_o = st_ff.stage2;

endmodule : pcgd_sync

// file: logic/pcgd_pad_mux.sv
`timescale 1ns/100ps
module pcgd_pad_mux (
    input  wire logic [pcgd_pkg::PORT_W-1:0] latch_i,
    input  wire logic [pcgd_pkg::PORT_W-1:0] dir_i,
    input  wire logic [pcgd_pkg::PORT_W-1:0] pull_i,
    input  wire logic [pcgd_pkg::PORT_W-1:0] slew_i,
    input  wire logic [pcgd_pkg::PORT_W-1:0] drive_i,
    input  wire logic                        gang_en_i,
    input  wire logic [pcgd_pkg::GANG_W:1]   gang_sel_i,
    input  wire logic [pcgd_pkg::GANG_W:1]   norm_out_i,
    input  wire logic [pcgd_pkg::GANG_W:1]   norm_oe_i,
    input  wire logic [pcgd_pkg::GANG_W:1]   norm_pull_i,
    input  wire logic [pcgd_pkg::GANG_W:1]   norm_slew_i,
    input  wire logic [pcgd_pkg::GANG_W:1]   norm_drive_i,
    output logic      [pcgd_pkg::PORT_W-1:0] dir_eff_o,
    output logic      [pcgd_pkg::PORT_W-1:0] pad_out_o,
    output logic      [pcgd_pkg::PORT_W-1:0] pad_oe_o,
    output logic      [pcgd_pkg::PORT_W-1:0] pad_pull_o,
    output logic      [pcgd_pkg::PORT_W-1:0] pad_slew_o,
    output logic      [pcgd_pkg::PORT_W-1:0] pad_drive_o,
    output logic      [pcgd_pkg::GANG_W:1]   gang_out_o,
    output logic      [pcgd_pkg::GANG_W:1]   gang_oe_o,
    output logic      [pcgd_pkg::GANG_W:1]   gang_pull_o,
    output logic      [pcgd_pkg::GANG_W:1]   gang_slew_o,
    output logic      [pcgd_pkg::GANG_W:1]   gang_drive_o
);
    import pcgd_pkg::*;

    genvar i;
    generate
        for (i = 0; i < PORT_W; i++) begin : g_port
            if (i == 0) begin : g_master
                assign dir_eff_o[i] = dir_i[i] | gang_en_i;
            end else begin : g_plain
                assign dir_eff_o[i] = dir_i[i];
            end
            assign pad_oe_o[i]    = dir_eff_o[i];
            assign pad_out_o[i]   = latch_i[i];
            assign pad_pull_o[i]  = pull_i[i] & ~dir_eff_o[i];
            // Inputs ignore slew and drive, so both read low there
            assign pad_slew_o[i]  = slew_i[i] & dir_eff_o[i];
            assign pad_drive_o[i] = drive_i[i] & dir_eff_o[i];
        end
        for (i = 1; i <= GANG_W; i++) begin : g_gang
            logic joined;
            assign joined          = gang_en_i & gang_sel_i[i];
            assign gang_out_o[i]   = joined ? latch_i[0] : norm_out_i[i];
            assign gang_oe_o[i]    = joined | norm_oe_i[i];
            assign gang_pull_o[i]  = joined ? 1'b0 : norm_pull_i[i];
            assign gang_slew_o[i]  = joined ? slew_i[0] : norm_slew_i[i];
            assign gang_drive_o[i] = joined ? drive_i[0] : norm_drive_i[i];
        end
    endgenerate

endmodule : pcgd_pad_mux

// file: logic/pcgd_top.sv
// How it works
// - Each pull-up bit connects its pin's pull-up when set, removes it when clear.
// - A pin driven as output always has its pull-up removed.
// - Each slew bit turns on slew limiting for its pin when set.
// - Slew and drive bits do nothing while the pin is an input.
// - Drive bit clear gives low drive, set gives high drive.
// - Gang select bits 7..1 take only the first write after reset.
// - Gang enable bit 0 takes only the first write after reset.
// - Gang enabled: selected pins copy pin 0 data, drive and slew.
// - Gang enabled: pin 0 is forced to output whatever its direction bit.
// - A selected pin joins the gang only while gang enable is one.
// - Direction bit 0 makes an input, 1 enables the output driver.
// - Reset makes all pins inputs, pull-ups off, data latch all zero.
//
// Our own choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/100ps
module pcgd_top (
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    input  wire logic                          wb_cyc_i,
    input  wire logic                          wb_stb_i,
    input  wire logic                          wb_we_i,
    input  wire logic [pcgd_pkg::WB_ADR_W-1:0] wb_adr_i,
    input  wire logic [pcgd_pkg::WB_SEL_W-1:0] wb_sel_i,
    input  wire logic [pcgd_pkg::WB_DAT_W-1:0] wb_dat_i,
    output logic      [pcgd_pkg::WB_DAT_W-1:0] wb_dat_o,
    output logic                               wb_ack_o,
    input  wire logic [pcgd_pkg::PORT_W-1:0]   pad_in_i,
    output logic      [pcgd_pkg::PORT_W-1:0]   pad_out_o,
    output logic      [pcgd_pkg::PORT_W-1:0]   pad_oe_o,
    output logic      [pcgd_pkg::PORT_W-1:0]   pad_pull_o,
    output logic      [pcgd_pkg::PORT_W-1:0]   pad_slew_o,
    output logic      [pcgd_pkg::PORT_W-1:0]   pad_drive_o,
    input  wire logic [pcgd_pkg::GANG_W:1]     gang_norm_out_i,
    input  wire logic [pcgd_pkg::GANG_W:1]     gang_norm_oe_i,
    input  wire logic [pcgd_pkg::GANG_W:1]     gang_norm_pull_i,
    input  wire logic [pcgd_pkg::GANG_W:1]     gang_norm_slew_i,
    input  wire logic [pcgd_pkg::GANG_W:1]     gang_norm_drive_i,
    output logic      [pcgd_pkg::GANG_W:1]     gang_out_o,
    output logic      [pcgd_pkg::GANG_W:1]     gang_oe_o,
    output logic      [pcgd_pkg::GANG_W:1]     gang_pull_o,
    output logic      [pcgd_pkg::GANG_W:1]     gang_slew_o,
    output logic      [pcgd_pkg::GANG_W:1]     gang_drive_o
);
    import pcgd_pkg::*;

    typedef struct packed {
        // Software registers
        logic [PORT_W-1:0]   pin_data_latch;
        logic [PORT_W-1:0]   pin_direction_bits;
        logic [PORT_W-1:0]   pull_up_enable_bits;
        logic [PORT_W-1:0]   slew_limit_enable_bits;
        logic [PORT_W-1:0]   drive_strength_bits;
        logic                gang_drive_enable;
        logic [GANG_W:1]     gang_pin_select_field;
        logic                gang_written;
        // Bus answer
        logic                ack;
        logic [WB_DAT_W-1:0] rdata;
        // Registered pad controls
        logic [PORT_W-1:0]   pad_out;
        logic [PORT_W-1:0]   pad_oe;
        logic [PORT_W-1:0]   pad_pull;
        logic [PORT_W-1:0]   pad_slew;
        logic [PORT_W-1:0]   pad_drive;
        logic [GANG_W:1]     gang_out;
        logic [GANG_W:1]     gang_oe;
        logic [GANG_W:1]     gang_pull;
        logic [GANG_W:1]     gang_slew;
        logic [GANG_W:1]     gang_drive;
    } pcgd_state_s;

    pcgd_state_s st_ff;
    pcgd_state_s nxt_st;

    logic [PORT_W-1:0] pin_level;
    logic [PORT_W-1:0] dir_eff;
    logic [PORT_W-1:0] mux_out;
    logic [PORT_W-1:0] mux_oe;
    logic [PORT_W-1:0] mux_pull;
    logic [PORT_W-1:0] mux_slew;
    logic [PORT_W-1:0] mux_drive;
    logic [GANG_W:1]   mux_gang_out;
    logic [GANG_W:1]   mux_gang_oe;
    logic [GANG_W:1]   mux_gang_pull;
    logic [GANG_W:1]   mux_gang_slew;
    logic [GANG_W:1]   mux_gang_drive;

    logic              req;
    logic              wr;
    logic [REG_W-1:0]  wbyte;
    logic [PORT_W-1:0] wnib;
    logic [PORT_W-1:0] data_view;
    logic [REG_W-1:0]  rbyte;

    // Pins are asynchronous to the bus clock
    pcgd_sync #(
        .WIDTH (PORT_W)
    ) u_pin_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i (pad_in_i),
        .sync_o  (pin_level)
    );

    pcgd_pad_mux u_pad_mux (
        .latch_i      (st_ff.pin_data_latch),
        .dir_i        (st_ff.pin_direction_bits),
        .pull_i       (st_ff.pull_up_enable_bits),
        .slew_i       (st_ff.slew_limit_enable_bits),
        .drive_i      (st_ff.drive_strength_bits),
        .gang_en_i    (st_ff.gang_drive_enable),
        .gang_sel_i   (st_ff.gang_pin_select_field),
        .norm_out_i   (gang_norm_out_i),
        .norm_oe_i    (gang_norm_oe_i),
        .norm_pull_i  (gang_norm_pull_i),
        .norm_slew_i  (gang_norm_slew_i),
        .norm_drive_i (gang_norm_drive_i),
        .dir_eff_o    (dir_eff),
        .pad_out_o    (mux_out),
        .pad_oe_o     (mux_oe),
        .pad_pull_o   (mux_pull),
        .pad_slew_o   (mux_slew),
        .pad_drive_o  (mux_drive),
        .gang_out_o   (mux_gang_out),
        .gang_oe_o    (mux_gang_oe),
        .gang_pull_o  (mux_gang_pull),
        .gang_slew_o  (mux_gang_slew),
        .gang_drive_o (mux_gang_drive)
    );

    // One new request per ack; the ack cycle itself is never retaken
    assign req   = wb_cyc_i & wb_stb_i & ~st_ff.ack;
    assign wr    = req & wb_we_i & wb_sel_i[REG_LANE];
    assign wbyte = wb_dat_i[REG_LANE*REG_W +: REG_W];
    assign wnib  = wbyte[PORT_W-1:0];

    // Outputs read back the latch, inputs read the pin
    assign data_view = (dir_eff & st_ff.pin_data_latch) | (~dir_eff & pin_level);

    always_comb begin
        rbyte = '0;
        unique case (wb_adr_i)
            OFS_DATA_LATCH: rbyte = {{(REG_W-PORT_W){1'b0}}, data_view};
            OFS_DIRECTION:  rbyte = {{(REG_W-PORT_W){1'b0}}, st_ff.pin_direction_bits};
            OFS_PULL_UP:    rbyte = {{(REG_W-PORT_W){1'b0}}, st_ff.pull_up_enable_bits};
            OFS_SLEW_LIMIT: rbyte = {{(REG_W-PORT_W){1'b0}}, st_ff.slew_limit_enable_bits};
            OFS_DRIVE_STR:  rbyte = {{(REG_W-PORT_W){1'b0}}, st_ff.drive_strength_bits};
            OFS_GANG_CTRL:  rbyte = {st_ff.gang_pin_select_field, st_ff.gang_drive_enable};
            default:        rbyte = '0;
        endcase
    end

    always_comb begin
        nxt_st     = st_ff;
        nxt_st.ack = req;
        if (req) begin
            nxt_st.rdata = {{(WB_DAT_W-REG_W){1'b0}}, rbyte};
        end
        if (wr) begin
            unique case (wb_adr_i)
                OFS_DATA_LATCH: nxt_st.pin_data_latch         = wnib;
                OFS_DIRECTION:  nxt_st.pin_direction_bits     = wnib;
                OFS_PULL_UP:    nxt_st.pull_up_enable_bits    = wnib;
                OFS_SLEW_LIMIT: nxt_st.slew_limit_enable_bits = wnib;
                OFS_DRIVE_STR:  nxt_st.drive_strength_bits    = wnib;
                OFS_GANG_CTRL: begin
                    // Lock guards against runaway code regrouping the pins
                    if (!st_ff.gang_written) begin
                        nxt_st.gang_drive_enable     = wbyte[GANG_EN_BIT];
                        nxt_st.gang_pin_select_field = wbyte[GANG_SEL_MSB:GANG_SEL_LSB];
                        nxt_st.gang_written          = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
        // Pad controls lag the registers by one cycle
        nxt_st.pad_out    = mux_out;
        nxt_st.pad_oe     = mux_oe;
        nxt_st.pad_pull   = mux_pull;
        nxt_st.pad_slew   = mux_slew;
        nxt_st.pad_drive  = mux_drive;
        nxt_st.gang_out   = mux_gang_out;
        nxt_st.gang_oe    = mux_gang_oe;
        nxt_st.gang_pull  = mux_gang_pull;
        nxt_st.gang_slew  = mux_gang_slew;
        nxt_st.gang_drive = mux_gang_drive;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff                        <= '0;
            st_ff.pin_data_latch         <= RST_DATA_LATCH;
            st_ff.pin_direction_bits     <= RST_DIRECTION;
            st_ff.pull_up_enable_bits    <= RST_PULL_UP;
            st_ff.slew_limit_enable_bits <= RST_SLEW_LIMIT;
            st_ff.drive_strength_bits    <= RST_DRIVE_STR;
            st_ff.gang_drive_enable      <= RST_GANG_EN;
            st_ff.gang_pin_select_field  <= RST_GANG_SEL;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign wb_dat_o     = st_ff.rdata;
    assign wb_ack_o     = st_ff.ack;
    assign pad_out_o    = st_ff.pad_out;
    assign pad_oe_o     = st_ff.pad_oe;
    assign pad_pull_o   = st_ff.pad_pull;
    assign pad_slew_o   = st_ff.pad_slew;
    assign pad_drive_o  = st_ff.pad_drive;
    assign gang_out_o   = st_ff.gang_out;
    assign gang_oe_o    = st_ff.gang_oe;
    assign gang_pull_o  = st_ff.gang_pull;
    assign gang_slew_o  = st_ff.gang_slew;
    assign gang_drive_o = st_ff.gang_drive;

endmodule : pcgd_top

// file: test/pcgd_top_sva.sv
`timescale 1ns/100ps
module pcgd_top_chk
    import pcgd_pkg::*;
(
    input wire logic                     clk_i,
    input wire logic                     rst_i,
    input wire logic                     wb_cyc_i,
    input wire logic                     wb_stb_i,
    input wire logic                     wb_we_i,
    input wire logic [WB_ADR_W-1:0]      wb_adr_i,
    input wire logic [WB_SEL_W-1:0]      wb_sel_i,
    input wire logic [WB_DAT_W-1:0]      wb_dat_i,
    input wire logic [WB_DAT_W-1:0]      wb_dat_o,
    input wire logic                     wb_ack_o,
    input wire logic [PORT_W-1:0]        pad_out_o,
    input wire logic [PORT_W-1:0]        pad_oe_o,
    input wire logic [PORT_W-1:0]        pad_pull_o,
    input wire logic [PORT_W-1:0]        pad_slew_o,
    input wire logic [PORT_W-1:0]        pad_drive_o,
    input wire logic [GANG_W:1]          gang_norm_out_i,
    input wire logic [GANG_W:1]          gang_norm_oe_i,
    input wire logic [GANG_W:1]          gang_norm_pull_i,
    input wire logic [GANG_W:1]          gang_norm_slew_i,
    input wire logic [GANG_W:1]          gang_norm_drive_i,
    input wire logic [GANG_W:1]          gang_out_o,
    input wire logic [GANG_W:1]          gang_oe_o,
    input wire logic [GANG_W:1]          gang_pull_o,
    input wire logic [GANG_W:1]          gang_slew_o,
    input wire logic [GANG_W:1]          gang_drive_o
);
    logic take;
    // A request is taken only while no ack is out
    assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ack_resp_a: assert property (take |=> wb_ack_o) else $error("no ack after request");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    dat_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000) else $error("upper read bits set");
    rst_state_a: assert property ($past(rst_i) |-> (pad_oe_o | pad_pull_o | pad_out_o) == 4'h0)
        else $error("pads not idle after reset");
    pull_off_a: assert property ((pad_pull_o & pad_oe_o) == 4'h0) else $error("pull on driven pin");
    input_quiet_a: assert property (((pad_slew_o | pad_drive_o) & ~pad_oe_o) == 4'h0)
        else $error("slew or drive on input pin");
    dir_write_a: assert property (take && wb_we_i && wb_sel_i[0] && wb_adr_i == OFS_DIRECTION
        |-> ##2 pad_oe_o[3:1] == $past(wb_dat_i[3:1], 2)) else $error("direction not applied");
    pull_write_a: assert property (take && wb_we_i && wb_sel_i[0] && wb_adr_i == OFS_PULL_UP
        |-> ##2 pad_pull_o == ($past(wb_dat_i[3:0], 2) & ~pad_oe_o)) else $error("pull not applied");
    gang_mirror_a: assert property (!$past(rst_i) |->
        ((gang_out_o ^ $past(gang_norm_out_i)) & (gang_out_o ^ {7{pad_out_o[0]}})) == 7'h00
        && ((gang_slew_o ^ $past(gang_norm_slew_i)) & (gang_slew_o ^ {7{pad_slew_o[0]}})) == 7'h00
        && ((gang_drive_o ^ $past(gang_norm_drive_i)) & (gang_drive_o ^ {7{pad_drive_o[0]}})) == 7'h00)
        else $error("gang pin not copying pin 0");
    gang_force_a: assert property (!$past(rst_i) && gang_oe_o != $past(gang_norm_oe_i)
        |-> pad_oe_o[0] && ((gang_oe_o ^ $past(gang_norm_oe_i)) & ~gang_oe_o) == 7'h00
        && ((gang_pull_o ^ $past(gang_norm_pull_i)) & gang_pull_o) == 7'h00) else $error("gang not forced");
    cover property (take && wb_we_i);
    cover property (pad_oe_o[0] && gang_oe_o != $past(gang_norm_oe_i));
    cover property ($past(rst_i) && !rst_i);
endmodule : pcgd_top_chk

bind pcgd_top pcgd_top_chk chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .pad_out_o, .pad_oe_o, .pad_pull_o, .pad_slew_o, .pad_drive_o, .gang_norm_out_i,
    .gang_norm_oe_i, .gang_norm_pull_i, .gang_norm_slew_i, .gang_norm_drive_i, .gang_out_o, .gang_oe_o,
    .gang_pull_o, .gang_slew_o, .gang_drive_o);

// file: test/pcgd_pins.sv
`timescale 1ns/100ps
module pcgd_pins (
    input  wire logic [pcgd_pkg::PORT_W-1:0] pad_out_i,
    input  wire logic [pcgd_pkg::PORT_W-1:0] pad_oe_i,
    input  wire logic [pcgd_pkg::PORT_W-1:0] pad_pull_i,
    input  wire logic                        clk_i,
    output logic      [pcgd_pkg::PORT_W-1:0] pad_in_o
);
    // Floating pin wanders so no stale level can pass for a pull-up
    logic [pcgd_pkg::PORT_W-1:0] float_ff = 4'h5;
    always @(posedge clk_i) begin
        float_ff <= ~float_ff;
    end
    assign pad_in_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & (pad_pull_i | float_ff & ~pad_pull_i));
endmodule : pcgd_pins

// file: test/tb_port_c_pad_control_ganged_drive.sv
`timescale 1ns/100ps
module tb_port_c_pad_control_ganged_drive;
    import pcgd_pkg::*;
    typedef struct {logic [7:0] adr; logic [7:0] wr; logic [7:0] exp;} pcgd_row_s;
    logic                clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [WB_ADR_W-1:0] wb_adr_i;
    logic [WB_SEL_W-1:0] wb_sel_i;
    logic [WB_DAT_W-1:0] wb_dat_i, wb_dat_o, rd;
    logic [PORT_W-1:0]   pad_in, p_out, p_oe, p_pull, p_slew, p_drive;
    logic [GANG_W:1]     n_out, n_oe, n_pull, n_slew, n_drive, g_out, g_oe, g_pull, g_slew, g_drive;
    int                  bad_count, samples_checked;
    // Pin 0 reads back its pull-up as an input; unmapped place last
    pcgd_row_s rows [6] = '{'{OFS_DIRECTION, 8'hfe, 8'h0e}, '{OFS_PULL_UP, 8'h0f, 8'h0f},
        '{OFS_SLEW_LIMIT, 8'h05, 8'h05}, '{OFS_DRIVE_STR, 8'h0a, 8'h0a}, '{OFS_DATA_LATCH, 8'h0d, 8'h0d},
        '{8'h18, 8'hff, 8'h00}};
    pcgd_top uut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
        .wb_ack_o, .pad_in_i(pad_in), .pad_out_o(p_out), .pad_oe_o(p_oe), .pad_pull_o(p_pull),
        .pad_slew_o(p_slew), .pad_drive_o(p_drive), .gang_norm_out_i(n_out), .gang_norm_oe_i(n_oe),
        .gang_norm_pull_i(n_pull), .gang_norm_slew_i(n_slew), .gang_norm_drive_i(n_drive), .gang_out_o(g_out),
        .gang_oe_o(g_oe), .gang_pull_o(g_pull), .gang_slew_o(g_slew), .gang_drive_o(g_drive));
    pcgd_pins pins (.pad_out_i(p_out), .pad_oe_i(p_oe), .pad_pull_i(p_pull), .clk_i, .pad_in_o(pad_in));
    task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask : chk_reg
    task automatic chk_pin(input string nm, input logic [6:0] e, input logic [6:0] g);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask : chk_pin
    task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'h1;
        wb_dat_i <= {24'h000000, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        if (wb_ack_o !== 1'b1) bad_count++;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb
    function automatic logic [6:0] gx(input logic [6:0] nrm, input logic [6:0] m, input logic v);
        return (nrm & ~m) | ({7{v}} & m);
    endfunction : gx
    // Mask m marks joined pins; o, s, d are pin 0 data, slew and drive
    task automatic gang_chk(input logic [6:0] m, input logic o, input logic s, input logic d);
        chk_pin("gang_out", gx(n_out, m, o), g_out);
        chk_pin("gang_oe", gx(n_oe, m, 1'b1), g_oe);
        chk_pin("gang_pull", gx(n_pull, m, 1'b0), g_pull);
        chk_pin("gang_slew", gx(n_slew, m, s), g_slew);
        chk_pin("gang_drive", gx(n_drive, m, d), g_drive);
    endtask : gang_chk
    // Called right on a rising edge, or at time zero so no edge sees unreset pads
    task automatic do_reset;
        rst_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(negedge clk_i);
        chk_pin("reset_pads", 7'h00, {3'h0, p_oe | p_pull | p_out});
    endtask : do_reset
    task final_report;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : final_report
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    initial begin
        #20000;
        bad_count++;
        final_report();
    end
    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
        {n_out, n_oe, n_pull, n_slew, n_drive} = {7'h55, 7'h33, 7'h0f, 7'h66, 7'h3c};
        do_reset();
        foreach (rows[i]) begin
            wb(1'b1, rows[i].adr, rows[i].wr);
            wb(1'b0, rows[i].adr, 8'h00);
            chk_reg("reg_read", {24'h000000, rows[i].exp}, rd);
        end
        repeat (2) @(negedge clk_i);
        chk_pin("pad_oe", 7'h0e, {3'h0, p_oe});
        chk_pin("pad_pull", 7'h01, {3'h0, p_pull});
        chk_pin("pad_slew", 7'h04, {3'h0, p_slew});
        chk_pin("pad_drive", 7'h0a, {3'h0, p_drive});
        chk_pin("pad_out", 7'h0d, {3'h0, p_out});
        wb(1'b1, OFS_GANG_CTRL, 8'h0b);
        wb(1'b1, OFS_GANG_CTRL, 8'h00);
        wb(1'b0, OFS_GANG_CTRL, 8'h00);
        chk_reg("gang_ctrl", 32'h0000000b, rd);
        repeat (2) @(negedge clk_i);
        chk_pin("pin0_forced", 7'h0f, {3'h0, p_oe});
        chk_pin("pin0_pull", 7'h00, {3'h0, p_pull});
        gang_chk(7'h05, 1'b1, 1'b1, 1'b0);
        @(posedge clk_i);
        {n_out, n_oe, n_pull, n_slew, n_drive} <= ~{n_out, n_oe, n_pull, n_slew, n_drive};
        do_reset();
        wb(1'b1, OFS_GANG_CTRL, 8'h0a);
        wb(1'b1, OFS_GANG_CTRL, 8'h0b);
        wb(1'b0, OFS_GANG_CTRL, 8'h00);
        chk_reg("gang_ctrl", 32'h0000000a, rd);
        repeat (2) @(negedge clk_i);
        chk_pin("pin0_free", 7'h00, {3'h0, p_oe});
        gang_chk(7'h00, 1'b0, 1'b0, 1'b0);
        final_report();
    end
endmodule : tb_port_c_pad_control_ganged_drive
